/* hdl/pcrc_top.sv */
// Programmable CRC generator with input FIFO and Wishbone slave.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps

module pcrc_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic idle_mode_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o
);

    // ==========================================================
    // Registers.
    logic en_q, idle_q, isel_q, go_q, lsbf_q;
    logic [4:0] width_q, plen_q, vw_q;
    logic [31:0] terms_q, result_q, stage_q, buf_q;
    logic [31:0] fifo_q [16];
    logic [3:0] wr_ptr_q, rd_ptr_q;
    logic [5:0] bits_left_q;
    pcrc_pkg::pcrc_state_t state_q;
    pcrc_pkg::pcrc_cfg_t cfg;

    logic req, wr, rd, run;
    logic push, pop, sw_go_wr;
    logic [4:0] depth;
    logic [1:0] top_byte;
    logic [31:0] mask, next_res;

    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i;
    assign rd = req && !we_i;
    // Halting in idle simply freezes the engine; registers stay reachable.
    assign run = en_q && !(idle_q && idle_mode_i);

    assign cfg = {plen_q, width_q, lsbf_q, terms_q};

    // Depth, valid-data mask and top byte all follow the word width.
    always_comb
    begin
        if (cfg.width >= pcrc_pkg::WIDTH_DEEP4)
            depth = pcrc_pkg::DEPTH_4;
        else if (cfg.width >= pcrc_pkg::WIDTH_DEEP8)
            depth = pcrc_pkg::DEPTH_8;
        else
            depth = pcrc_pkg::DEPTH_16;
        mask = 32'hffffffff >> (5'd31 - cfg.width);
        top_byte = cfg.width[4:3];
    end

    // A word is pushed when the byte carrying its MSb is written; lower
    // bytes of the other half-word must already stand in the staging word.
    always_comb
    begin
        push = 1'b0;
        if (wr && vw_q < depth)
        begin
            if (adr_i == pcrc_pkg::ADDR_DATA_LO)
                push = (top_byte[1] == 1'b0) && sel_i[top_byte];
            else if (adr_i == pcrc_pkg::ADDR_DATA_HI)
                push = top_byte[1] && sel_i[{1'b0, top_byte[0]}];
        end
    end

    assign pop = run && go_q && state_q == pcrc_pkg::ST_IDLE
        && vw_q != 5'h00;

    // Any software write of the go bit overrides the hardware clear.
    assign sw_go_wr = wr && adr_i == pcrc_pkg::ADDR_CTRL_ONE && sel_i[0];

    // ==========================================================
    // Wishbone acknowledge: one registered answer the cycle after the request, dropped next cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req;
    end

    // Configuration registers survive a disabled unit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en_q <= 1'b0;
            idle_q <= 1'b0;
            isel_q <= 1'b0;
            lsbf_q <= 1'b0;
            width_q <= 5'h00;
            plen_q <= 5'h00;
            terms_q <= 32'h00000000;
        end
        else if (wr)
        begin
            unique case (adr_i)
                pcrc_pkg::ADDR_CTRL_ONE:
                begin
                    if (sel_i[1])
                    begin
                        en_q <= dat_i[pcrc_pkg::EN_BIT];
                        idle_q <= dat_i[pcrc_pkg::IDLE_BIT];
                    end
                    if (sel_i[0])
                    begin
                        isel_q <= dat_i[pcrc_pkg::ISEL_BIT];
                        lsbf_q <= dat_i[pcrc_pkg::LSBF_BIT];
                    end
                end
                pcrc_pkg::ADDR_CTRL_TWO:
                begin
                    if (sel_i[1])
                        width_q <= dat_i[pcrc_pkg::WIDTH_LSB +: 5];
                    if (sel_i[0])
                        plen_q <= dat_i[pcrc_pkg::PLEN_LSB +: 5];
                end
                pcrc_pkg::ADDR_POLY_LO:
                begin
                    if (sel_i[0])
                        terms_q[7:1] <= dat_i[7:1];
                    if (sel_i[1])
                        terms_q[15:8] <= dat_i[15:8];
                end
                pcrc_pkg::ADDR_POLY_HI:
                begin
                    if (sel_i[0])
                        terms_q[23:16] <= dat_i[7:0];
                    if (sel_i[1])
                        terms_q[31:24] <= dat_i[15:8];
                end
                default: ;
            endcase
        end
    end

    // Go bit: software sets or clears; hardware clears when drained.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_q)
            go_q <= 1'b0;
        else if (sw_go_wr)
            go_q <= dat_i[pcrc_pkg::GO_BIT];
        else if (run && go_q && state_q == pcrc_pkg::ST_SHIFT
                 && bits_left_q <= 6'd2 && vw_q == 5'h00)
            go_q <= 1'b0;
    end

    // Staging word collects data bytes before a push.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_q)
            stage_q <= 32'h00000000;
        else if (wr && adr_i == pcrc_pkg::ADDR_DATA_LO)
        begin
            if (sel_i[0])
                stage_q[7:0] <= dat_i[7:0];
            if (sel_i[1])
                stage_q[15:8] <= dat_i[15:8];
        end
        else if (wr && adr_i == pcrc_pkg::ADDR_DATA_HI)
        begin
            if (sel_i[0])
                stage_q[23:16] <= dat_i[7:0];
            if (sel_i[1])
                stage_q[31:24] <= dat_i[15:8];
        end
    end

    // ==========================================================
    // FIFO storage; the pushed word merges the half-word written this cycle.
    always_ff @(posedge clk_i)
    begin
        if (push && adr_i == pcrc_pkg::ADDR_DATA_LO)
            fifo_q[wr_ptr_q] <= {stage_q[31:16], dat_i[15:0]} & mask;
        else if (push)
            fifo_q[wr_ptr_q] <= {dat_i[15:0], stage_q[15:0]} & mask;
    end

    // Pointers and valid-word count.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_q)
        begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            vw_q <= 5'h00;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 4'h1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 4'h1;
            if (push && !pop)
                vw_q <= vw_q + 5'h01;
            else if (pop && !push)
                vw_q <= vw_q - 5'h01;
        end
    end

    // ==========================================================
    // Engine: IDLE takes a word, LOAD settles it, SHIFT runs two bits.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_q)
        begin
            state_q <= pcrc_pkg::ST_IDLE;
            buf_q <= 32'h00000000;
            bits_left_q <= 6'h00;
        end
        else if (run)
        begin
            unique case (state_q)
                pcrc_pkg::ST_IDLE:
                    if (pop)
                    begin
                        buf_q <= fifo_q[rd_ptr_q];
                        bits_left_q <= {1'b0, cfg.width} + 6'h01;
                        state_q <= pcrc_pkg::ST_LOAD;
                    end
                pcrc_pkg::ST_LOAD:
                    state_q <= pcrc_pkg::ST_SHIFT;
                pcrc_pkg::ST_SHIFT:
                    if (go_q)
                    begin
                        if (cfg.lsb_first)
                            buf_q <= buf_q >> 2;
                        else
                            buf_q <= buf_q << 2;
                        if (bits_left_q <= 6'd2)
                        begin
                            bits_left_q <= 6'h00;
                            state_q <= pcrc_pkg::ST_IDLE;
                        end
                        else
                            bits_left_q <= bits_left_q - 6'd2;
                    end
                default:
                    state_q <= pcrc_pkg::ST_IDLE;
            endcase
        end
    end

    // One serial step of the remainder for data bit d.
    function automatic logic [31:0] crc_step
    (
        input logic [31:0] r,
        input logic d,
        input pcrc_pkg::pcrc_cfg_t c
    );
        logic fb;
        logic [31:0] taps;
        fb = r[c.plen] ^ d;
        taps = {c.terms[31:1], 1'b1};
        crc_step = (r << 1) ^ (fb ? taps : 32'h00000000);
        crc_step = crc_step & (32'hffffffff >> (5'd31 - c.plen));
    endfunction

    // Next data bits in entry order, and the remainder after two of them, or after one when one bit is left.
    always_comb
    begin
        logic b0, b1;
        b0 = cfg.lsb_first ? buf_q[0] : buf_q[cfg.width];
        b1 = cfg.lsb_first ? buf_q[1]
            : buf_q[cfg.width - 5'h01];
        next_res = crc_step(result_q, b0, cfg);
        if (bits_left_q >= 6'd2)
            next_res = crc_step(next_res, b1, cfg);
    end

    // Result register: software seed, else running remainder.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_q)
            result_q <= 32'h00000000;
        else if (wr && adr_i == pcrc_pkg::ADDR_RES_LO)
        begin
            if (sel_i[0])
                result_q[7:0] <= dat_i[7:0];
            if (sel_i[1])
                result_q[15:8] <= dat_i[15:8];
        end
        else if (wr && adr_i == pcrc_pkg::ADDR_RES_HI)
        begin
            if (sel_i[0])
                result_q[23:16] <= dat_i[7:0];
            if (sel_i[1])
                result_q[31:24] <= dat_i[15:8];
        end
        else if (run && go_q && state_q == pcrc_pkg::ST_SHIFT)
            result_q <= next_res;
    end

    // Interrupt pulse, one cycle, on the selected event only.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_q)
            irq_o <= 1'b0;
        else if (!isel_q)
            irq_o <= pop && !push && vw_q == 5'h01;
        else
            irq_o <= run && go_q && !sw_go_wr
                && state_q == pcrc_pkg::ST_SHIFT
                && bits_left_q <= 6'd2 && vw_q == 5'h00;
    end

    // ==========================================================
    // Read data, registered with the acknowledge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h00000000;
        else if (rd)
        begin
            unique case (adr_i)
                pcrc_pkg::ADDR_CTRL_ONE:
                    dat_o <= {16'h0000, en_q, 1'b0, idle_q, vw_q,
                        vw_q >= depth,
                        vw_q == 5'h00,
                        isel_q, go_q, lsbf_q, 3'h0};
                pcrc_pkg::ADDR_CTRL_TWO:
                    dat_o <= {19'h00000, width_q, 3'h0, plen_q};
                pcrc_pkg::ADDR_POLY_LO:
                    dat_o <= {16'h0000, terms_q[15:1], 1'b0};
                pcrc_pkg::ADDR_POLY_HI:
                    dat_o <= {16'h0000, terms_q[31:16]};
                pcrc_pkg::ADDR_RES_LO:
                    dat_o <= {16'h0000, result_q[15:0]};
                pcrc_pkg::ADDR_RES_HI:
                    dat_o <= {16'h0000, result_q[31:16]};
                default:
                    dat_o <= 32'h00000000;
            endcase
        end
    end

endmodule

/* common/pcrc_pkg.sv */
// Package with register map, field positions and types of the CRC generator.
package pcrc_pkg;

    // ==========================================================
    // Register word addresses (byte address on the Wishbone bus).
    localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
    localparam logic [4:0] ADDR_CTRL_TWO = 5'h04;
    localparam logic [4:0] ADDR_POLY_LO = 5'h08;
    localparam logic [4:0] ADDR_POLY_HI = 5'h0c;
    localparam logic [4:0] ADDR_DATA_LO = 5'h10;
    localparam logic [4:0] ADDR_DATA_HI = 5'h14;
    localparam logic [4:0] ADDR_RES_LO = 5'h18;
    localparam logic [4:0] ADDR_RES_HI = 5'h1c;

    // ==========================================================
    // Field positions in crc_control_one.
    localparam int EN_BIT = 15;
    localparam int IDLE_BIT = 13;
    localparam int VW_LSB = 8;
    localparam int FULL_BIT = 7;
    localparam int EMPTY_BIT = 6;
    localparam int ISEL_BIT = 5;
    localparam int GO_BIT = 4;
    localparam int LSBF_BIT = 3;
    // Field positions in crc_control_two.
    localparam int WIDTH_LSB = 8;
    localparam int PLEN_LSB = 0;

    // ==========================================================
    // Reset values and depth thresholds.
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [4:0] WIDTH_DEEP8 = 5'h08;
    localparam logic [4:0] WIDTH_DEEP4 = 5'h10;
    localparam logic [4:0] DEPTH_4 = 5'h04;
    localparam logic [4:0] DEPTH_8 = 5'h08;
    localparam logic [4:0] DEPTH_16 = 5'h10;

    // Engine states.
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_SHIFT = 3'b100
    } pcrc_state_t;

    // Configuration word as seen by the engine.
    typedef struct packed
    {
        logic [4:0] plen;
        logic [4:0] width;
        logic lsb_first;
        logic [31:0] terms;
    } pcrc_cfg_t;

endpackage

/* bench/pcrc_top_chk.sv */
// Checker of bus timing, interrupt pulses and read-back of the CRC unit.
`timescale 1ns/1ps

// ==========================================================
// Checker module bound to the top of the CRC generator.
module pcrc_top_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic idle_mode_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A request taken at this edge, and a read of one address.
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_rd(logic [4:0] a);
        s_take ##0 (!we_i && adr_i == a);
    endsequence

    // Each request gets exactly one answer in the following cycle.
    a_ack_next: assert property (s_take |=> ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    // The interrupt is a single-cycle pulse.
    a_irq_pulse: assert property (irq_o |=> !irq_o)
        else $error("interrupt longer than one cycle");
    // Term bit zero has no storage and reads as zero.
    a_term_zero: assert property (
        s_rd(pcrc_pkg::ADDR_POLY_LO) |=> !dat_o[0])
        else $error("term bit zero reads one");
    // Empty flag follows a zero word count.
    a_empty_flag: assert property (
        s_rd(pcrc_pkg::ADDR_CTRL_ONE) |=>
        dat_o[pcrc_pkg::EMPTY_BIT] == (dat_o[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    // Count never passes the deepest FIFO; full needs at least four.
    a_count_bound: assert property (
        s_rd(pcrc_pkg::ADDR_CTRL_ONE) |=> dat_o[12:8] <= 5'h10 &&
        (!dat_o[pcrc_pkg::FULL_BIT] || dat_o[12:8] >= 5'h04))
        else $error("count or full flag out of range");
    a_ctrl_unused: assert property (
        s_rd(pcrc_pkg::ADDR_CTRL_TWO) |=>
        dat_o[31:13] == 19'h0 && dat_o[7:5] == 3'h0)
        else $error("unused control bits read one");
    a_data_hi_zero: assert property (
        s_rd(pcrc_pkg::ADDR_DATA_HI) |=> dat_o == 32'h0)
        else $error("data register reads nonzero");
endmodule

bind pcrc_top pcrc_top_chk i_pcrc_top_chk
(
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .idle_mode_i(idle_mode_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o)
);

/* bench/test_pcrc_top.sv */
// Self-checking bench of the programmable CRC generator.
`timescale 1ns/1ps

// ==========================================================
// Bench top with clock, bus tasks and tests.
module test_pcrc_top;
    logic clk_i;
    logic rst_i;
    logic cyc_i;
    logic stb_i;
    logic we_i;
    logic [4:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i;
    logic idle_mode_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int irqs = 0;

    pcrc_top i_pcrc_top
    (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .idle_mode_i(idle_mode_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o)
    );

    // Free-running 40 MHz clock.
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Counts interrupt pulses; the ceiling is far above the test length.
    always @(posedge clk_i)
    begin
        cycles++;
        if (irq_o === 1'b1) irqs++;
        if (cycles == 6000)
        begin
            fails++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; read data is taken at the ack edge.
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // Reference remainder of an 8-bit polynomial x8+x2+x+1, one byte.
    function automatic logic [7:0] crc8(input logic [7:0] r,
                                        input logic [7:0] b,
                                        input logic lsb);
        logic d;
        for (int k = 0; k < 8; k++)
        begin
            d = lsb ? b[k] : b[7 - k];
            r = (d ^ r[7]) ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        return r;
    endfunction

    // Fills the FIFO at one width until a word is refused, then disables.
    task automatic depth(input logic [4:0] w, input logic [4:0] n);
        logic [31:0] c2;
        c2 = {19'h0, w, 8'h07};
        wr(pcrc_pkg::ADDR_CTRL_ONE, 32'h8000);
        wr(pcrc_pkg::ADDR_CTRL_TWO, c2);
        repeat (n + 1)
            wr(w < 5'h10 ? pcrc_pkg::ADDR_DATA_LO : pcrc_pkg::ADDR_DATA_HI,
               32'h00ff);
        rd(pcrc_pkg::ADDR_CTRL_ONE, {16'h0, 3'b100, n, 8'h80});
        wr(pcrc_pkg::ADDR_CTRL_ONE, 32'h0);
        rd(pcrc_pkg::ADDR_CTRL_ONE, 32'h0040);
        rd(pcrc_pkg::ADDR_CTRL_TWO, c2);
    endtask

    // Loads four bytes with go low, starts, then compares the remainder.
    // Loading first keeps the FIFO from draining between words.
    task automatic crc_run(input logic lsb, input logic park,
                           input logic isel);
        logic [31:0] c;
        logic [7:0] r;
        logic [7:0] b;
        int n0;
        c = {16'h0, 1'b1, 1'b0, park, 7'h0, isel, 1'b0, lsb, 3'h0};
        r = 8'h5a;
        n0 = irqs;
        wr(pcrc_pkg::ADDR_CTRL_ONE, 32'h0);
        wr(pcrc_pkg::ADDR_CTRL_ONE, c);
        wr(pcrc_pkg::ADDR_CTRL_TWO, 32'h0707); // Width equals length.
        wr(pcrc_pkg::ADDR_POLY_LO, 32'h0006);
        wr(pcrc_pkg::ADDR_POLY_HI, 32'h0);
        wr(pcrc_pkg::ADDR_RES_LO, 32'h005a);
        for (int i = 0; i < 4; i++)
        begin
            b = 8'(8'h31 + 8'h47 * i);
            wr(pcrc_pkg::ADDR_DATA_LO, {24'h0, b});
            r = crc8(r, b, lsb);
        end
        rd(pcrc_pkg::ADDR_CTRL_ONE, c | 32'h0400);
        idle_mode_i <= park;
        wr(pcrc_pkg::ADDR_CTRL_ONE, c | 32'h10);
        if (park)
        begin
            repeat (20) @(posedge clk_i);
            rd(pcrc_pkg::ADDR_CTRL_ONE, c | 32'h0410);
            idle_mode_i <= 1'b0;
        end
        while (irq_o !== 1'b1) @(posedge clk_i);
        repeat (isel ? 4 : 8) @(posedge clk_i);
        if (isel)
            rd(pcrc_pkg::ADDR_CTRL_ONE, c | 32'h0040);
        rd(pcrc_pkg::ADDR_RES_LO, {24'h0, r});
        rd(pcrc_pkg::ADDR_RES_HI, 32'h0);
        check(32'(irqs - n0), 32'h1);
        // Flush with go cycled: one zero byte extends the message.
        if (isel)
        begin
            wr(pcrc_pkg::ADDR_CTRL_ONE, c);
            wr(pcrc_pkg::ADDR_DATA_LO, 32'h0);
            r = crc8(r, 8'h00, lsb);
            wr(pcrc_pkg::ADDR_CTRL_ONE, c | 32'h10);
            while (irq_o !== 1'b1) @(posedge clk_i);
            repeat (4) @(posedge clk_i);
            rd(pcrc_pkg::ADDR_RES_LO, {24'h0, r});
            check(32'(irqs - n0), 32'h2);
        end
    endtask

    // Reset, register map, FIFO depths and three CRC runs.
    initial
    begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 5'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        idle_mode_i = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(pcrc_pkg::ADDR_CTRL_ONE, 32'h0040);
        rd(pcrc_pkg::ADDR_CTRL_TWO, 32'h0);
        rd(pcrc_pkg::ADDR_DATA_HI, 32'h0);
        wr(pcrc_pkg::ADDR_POLY_LO, 32'hffff);
        rd(pcrc_pkg::ADDR_POLY_LO, 32'hfffe);
        wr(pcrc_pkg::ADDR_POLY_HI, 32'ha5c3);
        rd(pcrc_pkg::ADDR_POLY_HI, 32'ha5c3);
        depth(5'h07, 5'h10);
        depth(5'h08, 5'h08);
        depth(5'h0f, 5'h08);
        depth(5'h10, 5'h04);
        crc_run(1'b0, 1'b0, 1'b1);
        crc_run(1'b1, 1'b1, 1'b1);
        crc_run(1'b0, 1'b0, 1'b0);
        stop_test();
    end
endmodule
